// ### usbec_cfg.svh
// constants of the usb endpoint control block: offsets, field positions, resets
// assumes inclusion by its bare name from every design file that needs them
`ifndef USBEC_CFG_SVH
`define USBEC_CFG_SVH
`define USBEC_NUM_EP 7
`define USBEC_EP_NONE 3'h7
`define USBEC_RST_BYTE 8'h00
// endpoint register bus offsets
`define USBEC_OFS_ADDR 4'h0
`define USBEC_OFS_FRM_HI 4'h1
`define USBEC_OFS_FRM_LO 4'h2
`define USBEC_OFS_FRM_ERR 4'h3
`define USBEC_OFS_SEL 4'h4
`define USBEC_OFS_FRST 4'h5
`define USBEC_OFS_CTRL 4'h6
`define USBEC_OFS_TYPE 4'h7
`define USBEC_OFS_SIZE 4'h8
`define USBEC_OFS_STA 4'h9
`define USBEC_OFS_STB 4'hA
`define USBEC_OFS_FLG 4'hB
`define USBEC_OFS_IEN 4'hC
`define USBEC_OFS_DATA 4'hD
`define USBEC_OFS_SUM 4'hE
// field positions
`define USBEC_B_ADDR_ACT 7
`define USBEC_F_ADDR 6:0
`define USBEC_F_FRM_HI 10:8
`define USBEC_F_FRM_LO 7:0
`define USBEC_B_FRM_CRC 4
`define USBEC_F_SEL 2:0
`define USBEC_B_STALL_RQ 5
`define USBEC_B_STALL_CAN 4
`define USBEC_B_TOG_RST 3
`define USBEC_B_ACTIVE 0
`define USBEC_F_KIND 7:6
`define USBEC_B_DIR 0
`define USBEC_F_SIZE 6:4
`define USBEC_F_BANK 3:2
`define USBEC_B_CLAIM 1
`define USBEC_B_VALID 7
`define USBEC_B_OVR 6
`define USBEC_B_UND 5
`define USBEC_F_TOG 3:2
`define USBEC_F_BUSY 1:0
`define USBEC_B_CDIR 2
`define USBEC_F_CURB 1:0
`define USBEC_B_RELEASE 7
`define USBEC_B_IN_NAK 6
`define USBEC_B_ACCESS 5
`define USBEC_B_OUT_NAK 4
`define USBEC_B_SETUP 3
`define USBEC_B_OUT_RCV 2
`define USBEC_B_STALL_SENT 1
`define USBEC_B_IN_RDY 0
`define USBEC_B_FLOW_EN 7
`define USBEC_IEN_MASK 8'hDF
`define USBEC_KIND_ISO 2'h1
`define USBEC_SIZE_BASE 12'h008
// wishbone side of the controller end
`define USBEC_WB_OFS_CMD 4'h0
`define USBEC_WB_OFS_STAT 4'h4
`define USBEC_F_CMD_DATA 7:0
`define USBEC_F_CMD_ADDR 11:8
`define USBEC_B_CMD_WE 16
`define USBEC_B_STAT_BUSY 8
`define USBEC_B_STAT_REF 9
`endif

// ### usbec_pkg.sv
// types of the endpoint register link, and the sequencer states of the host end
// assumes nothing beyond a systemverilog compiler
package usbec_pkg;
   typedef logic [7:0] usbec_byte_t;
   typedef logic [3:0] usbec_ofs_t;
   typedef enum logic [0:0] {usbec_idle, usbec_wait} usbec_hstate_t;
endpackage : usbec_pkg

// ### usbec_if.sv
// byte register link between the endpoint logic and its controller
// assumes one shared clock; req holds until ack, ack is one cycle
`timescale 1ns/1ps
interface usbec_if;
   logic req;
   logic we;
   usbec_pkg::usbec_ofs_t addr;
   usbec_pkg::usbec_byte_t wdata;
   logic ack;
   usbec_pkg::usbec_byte_t rdata;
   modport device (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : usbec_if

// ### usbec_device.sv
// endpoint control and status logic of a usb full/low speed device
// assumes a usb engine on the user side giving one-cycle event pulses for usb_ep_i
//
// Design decisions made here: the byte register link port and the register addresses.
`timescale 1ns/1ps
`include "usbec_cfg.svh"
module usbec_device #(
   parameter int DEPTH = 64,
   parameter int MAX_SIZE = 6,
   parameter int MAX_BYTES = 512,
   parameter int MAX_BANKS = 2
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register link
   usbec_if.device bus,
   // frame events
   input wire logic sof_i,
   input wire logic [10:0] sof_frame_i,
   input wire logic sof_crc_bad_i,
   // endpoint events from the usb engine
   input wire logic [2:0] usb_ep_i,
   input wire logic setup_i,
   input wire logic setup_dir_i,
   input wire logic out_done_i,
   input wire logic out_toggle_i,
   input wire logic in_done_i,
   input wire logic nak_in_i,
   input wire logic nak_out_i,
   input wire logic stall_sent_i,
   input wire logic crc_err_i,
   input wire logic overflow_i,
   input wire logic underflow_i,
   // byte stream to and from the usb engine
   input wire logic usb_push_i,
   input wire logic usb_pop_i,
   input wire logic [7:0] usb_data_i,
   output logic [7:0] usb_data_o,
   // state seen by the usb engine
   output logic [6:0] dev_addr_o,
   output logic frame_start_o,
   output logic [6:0] stall_o,
   output logic [6:0] active_o,
   output logic [6:0] clear_o,
   output logic [6:0] toggle_o,
   output logic [6:0] ep_irq_o
);
   localparam int NE = `USBEC_NUM_EP;
   localparam int PW = $clog2(DEPTH);
   logic [7:0] mem [8*DEPTH];
   logic [PW-1:0] wp [NE];
   logic [PW-1:0] rp [NE];
   logic [PW:0] cnt [NE];
   logic [6:0] addr_field;
   logic [10:0] frame_count;
   logic frame_crc_bad;
   logic [2:0] sel;
   logic [1:0] kind [NE];
   logic [NE-1:0] dir, claim, setup_valid, overrun, underrun, cdir, curb, release_f;
   logic [NE-1:0] in_nak, out_nak, setup_f, out_rcv, stall_sent, in_rdy, discard;
   logic [2:0] fsize [NE];
   logic [1:0] bank [NE];
   logic [1:0] busy [NE];
   logic [7:0] ien [NE];
   logic [7:0] rd_mux;
   logic [NE-1:0] rel_clr, rel_set, can_access, hit;
   logic taken, wr, rd, ep_ok;
   logic [11:0] need_bytes;

   assign taken = bus.req & ~bus.ack;
   assign wr = taken & bus.we;
   assign rd = taken & ~bus.we;
   assign ep_ok = sel != `USBEC_EP_NONE;
   // bytes per bank a claim would take, from the size write itself
   assign need_bytes = `USBEC_SIZE_BASE << bus.wdata[`USBEC_F_SIZE];

   // per endpoint combinational terms
   always_comb begin
      for (int e = 0; e < NE; e++) begin
         hit[e] = usb_ep_i == 3'(e);
         rel_clr[e] = wr && bus.addr == `USBEC_OFS_FLG && sel == 3'(e)
                      && !bus.wdata[`USBEC_B_RELEASE] && release_f[e];
         // out: new packet, or next full bank after a release; in: a free bank
         if (!dir[e]) begin
            rel_set[e] = hit[e] & (out_done_i | setup_i) | (rel_clr[e] & busy[e] > 2'h1);
         end else begin
            rel_set[e] = active_o[e] & ~clear_o[e] & ~release_f[e] & ~rel_clr[e]
                         & (busy[e] <= {1'b0, bank[e][0]});
         end
         can_access[e] = release_f[e] & ~stall_o[e] & ~(overrun[e] | underrun[e])
                         & (dir[e] ? cnt[e] != (PW+1)'(DEPTH) : cnt[e] != '0);
      end
   end

   // bus acknowledge and registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus.ack <= 1'b0;
         bus.rdata <= `USBEC_RST_BYTE;
      end else begin
         bus.ack <= taken;
         if (rd) bus.rdata <= rd_mux;
      end
   end

   // read decode; per endpoint registers follow the selector
   always_comb begin
      rd_mux = `USBEC_RST_BYTE;
      if (bus.addr == `USBEC_OFS_ADDR) begin
         rd_mux = {1'b0, addr_field};
      end else if (bus.addr == `USBEC_OFS_FRM_HI) begin
         rd_mux = {5'h00, frame_count[`USBEC_F_FRM_HI]};
      end else if (bus.addr == `USBEC_OFS_FRM_LO) begin
         rd_mux = frame_count[`USBEC_F_FRM_LO];
      end else if (bus.addr == `USBEC_OFS_FRM_ERR) begin
         rd_mux[`USBEC_B_FRM_CRC] = frame_crc_bad;
      end else if (bus.addr == `USBEC_OFS_SEL) begin
         rd_mux = {5'h00, sel};
      end else if (bus.addr == `USBEC_OFS_FRST) begin
         rd_mux = {1'b0, clear_o};
      end else if (bus.addr == `USBEC_OFS_SUM) begin
         rd_mux = {1'b0, ep_irq_o};
      end else if (ep_ok) begin
         if (bus.addr == `USBEC_OFS_CTRL) begin
            rd_mux[`USBEC_B_STALL_RQ] = stall_o[sel];
            rd_mux[`USBEC_B_ACTIVE] = active_o[sel];
         end else if (bus.addr == `USBEC_OFS_TYPE) begin
            rd_mux[`USBEC_F_KIND] = kind[sel];
            rd_mux[`USBEC_B_DIR] = dir[sel];
         end else if (bus.addr == `USBEC_OFS_SIZE) begin
            rd_mux[`USBEC_F_SIZE] = fsize[sel];
            rd_mux[`USBEC_F_BANK] = bank[sel];
            rd_mux[`USBEC_B_CLAIM] = claim[sel];
         end else if (bus.addr == `USBEC_OFS_STA) begin
            rd_mux = {setup_valid[sel], overrun[sel], underrun[sel], 1'b0,
                      1'b0, toggle_o[sel], busy[sel]};
         end else if (bus.addr == `USBEC_OFS_STB) begin
            rd_mux = {5'h00, cdir[sel], 1'b0, curb[sel]};
         end else if (bus.addr == `USBEC_OFS_FLG) begin
            rd_mux = {release_f[sel], in_nak[sel], can_access[sel], out_nak[sel],
                      setup_f[sel], dir[sel] ? discard[sel] : out_rcv[sel],
                      stall_sent[sel], in_rdy[sel]};
         end else if (bus.addr == `USBEC_OFS_IEN) begin
            rd_mux = ien[sel];
         end else if (bus.addr == `USBEC_OFS_DATA) begin
            rd_mux = mem[{sel, rp[sel]}];
         end
      end
   end

   // device wide registers and frame capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_field <= 7'h00;
         dev_addr_o <= 7'h00;
         sel <= 3'h0;
         clear_o <= 7'h00;
         frame_count <= 11'h000;
         frame_crc_bad <= 1'b0;
         frame_start_o <= 1'b0;
      end else begin
         if (wr && bus.addr == `USBEC_OFS_ADDR) begin
            addr_field <= bus.wdata[`USBEC_F_ADDR];
            // the answering address changes only on activation
            if (bus.wdata[`USBEC_B_ADDR_ACT]) dev_addr_o <= bus.wdata[`USBEC_F_ADDR];
         end
         if (wr && bus.addr == `USBEC_OFS_SEL) sel <= bus.wdata[`USBEC_F_SEL];
         if (wr && bus.addr == `USBEC_OFS_FRST) clear_o <= bus.wdata[6:0];
         // a corrupted sof still updates the number
         frame_start_o <= sof_i;
         if (sof_i) begin
            frame_count <= sof_frame_i;
            frame_crc_bad <= sof_crc_bad_i;
         end
      end
   end

   // per endpoint control and configuration
   always_ff @(posedge clk_i) begin
      for (int e = 0; e < NE; e++) begin
         if (rst_i) begin
            stall_o[e] <= 1'b0;
            active_o[e] <= 1'b0;
            kind[e] <= 2'h0;
            dir[e] <= 1'b0;
            fsize[e] <= 3'h0;
            bank[e] <= 2'h0;
            claim[e] <= 1'b0;
            setup_valid[e] <= 1'b0;
            ien[e] <= `USBEC_RST_BYTE;
         end else if (wr && sel == 3'(e)) begin
            if (bus.addr == `USBEC_OFS_CTRL) begin
               if (bus.wdata[`USBEC_B_STALL_CAN]) stall_o[e] <= 1'b0;
               else if (bus.wdata[`USBEC_B_STALL_RQ]) stall_o[e] <= 1'b1;
               active_o[e] <= bus.wdata[`USBEC_B_ACTIVE];
            end else if (bus.addr == `USBEC_OFS_TYPE) begin
               kind[e] <= bus.wdata[`USBEC_F_KIND];
               dir[e] <= bus.wdata[`USBEC_B_DIR];
            end else if (bus.addr == `USBEC_OFS_SIZE) begin
               fsize[e] <= bus.wdata[`USBEC_F_SIZE];
               bank[e] <= bus.wdata[`USBEC_F_BANK];
               claim[e] <= bus.wdata[`USBEC_B_CLAIM];
               if (bus.wdata[`USBEC_B_CLAIM]) begin
                  setup_valid[e] <= 32'(bus.wdata[`USBEC_F_SIZE]) <= MAX_SIZE
                     && 32'(bus.wdata[`USBEC_F_BANK]) < MAX_BANKS
                     && 32'(need_bytes) * (32'(bus.wdata[`USBEC_F_BANK]) + 1) <= MAX_BYTES;
               end
            end else if (bus.addr == `USBEC_OFS_IEN) begin
               ien[e] <= bus.wdata & `USBEC_IEN_MASK;
            end
         end else if (hit[e] && setup_i) begin
            stall_o[e] <= 1'b0;
         end
      end
   end

   // per endpoint banks, toggle and direction state
   always_ff @(posedge clk_i) begin
      for (int e = 0; e < NE; e++) begin
         if (rst_i || clear_o[e]) begin
            busy[e] <= 2'h0;
            curb[e] <= 1'b0;
            release_f[e] <= 1'b0;
            discard[e] <= 1'b0;
            toggle_o[e] <= 1'b0;
            cdir[e] <= 1'b0;
         end else begin
            if (rel_set[e]) release_f[e] <= 1'b1;
            else if (rel_clr[e]) release_f[e] <= 1'b0;
            if (rel_clr[e] && bank[e][0]) curb[e] <= ~curb[e];
            if (!dir[e]) begin
               busy[e] <= busy[e] + 2'(hit[e] & out_done_i) - 2'(rel_clr[e]);
            end else begin
               busy[e] <= busy[e] + 2'(rel_clr[e]) - 2'(hit[e] & in_done_i)
                          - 2'(discard[e] & ~(hit[e] & in_done_i) & (busy[e] != 2'h0));
            end
            if (wr && sel == 3'(e) && bus.addr == `USBEC_OFS_FLG && dir[e]
                && bus.wdata[`USBEC_B_OUT_RCV]) discard[e] <= 1'b1;
            else discard[e] <= 1'b0;
            if (wr && sel == 3'(e) && bus.addr == `USBEC_OFS_CTRL
                && bus.wdata[`USBEC_B_TOG_RST]) toggle_o[e] <= 1'b0;
            else if (hit[e] && out_done_i && !dir[e]) toggle_o[e] <= out_toggle_i;
            else if (hit[e] && in_done_i && dir[e]) toggle_o[e] <= ~toggle_o[e];
            if (hit[e] && setup_i) cdir[e] <= setup_dir_i;
         end
      end
   end

   // sticky flags: a hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      for (int e = 0; e < NE; e++) begin
         if (rst_i) begin
            {overrun[e], underrun[e], in_nak[e], out_nak[e]} <= 4'h0;
            {setup_f[e], out_rcv[e], stall_sent[e], in_rdy[e]} <= 4'h0;
            ep_irq_o[e] <= 1'b0;
         end else begin
            logic c;
            c = wr && sel == 3'(e);
            overrun[e] <= overrun[e] & ~(c && bus.addr == `USBEC_OFS_STA
               && !bus.wdata[`USBEC_B_OVR]) | hit[e] & overflow_i & kind[e] == `USBEC_KIND_ISO;
            underrun[e] <= underrun[e] & ~(c && bus.addr == `USBEC_OFS_STA
               && !bus.wdata[`USBEC_B_UND]) | hit[e] & underflow_i & kind[e] == `USBEC_KIND_ISO;
            c = c && bus.addr == `USBEC_OFS_FLG;
            in_nak[e] <= in_nak[e] & ~(c & ~bus.wdata[`USBEC_B_IN_NAK]) | hit[e] & nak_in_i;
            out_nak[e] <= out_nak[e] & ~(c & ~bus.wdata[`USBEC_B_OUT_NAK]) | hit[e] & nak_out_i;
            setup_f[e] <= setup_f[e] & ~(c & ~bus.wdata[`USBEC_B_SETUP])
                          | hit[e] & setup_i & ~dir[e];
            out_rcv[e] <= out_rcv[e] & ~(c & ~bus.wdata[`USBEC_B_OUT_RCV] & ~dir[e])
                          | rel_set[e] & ~dir[e] & ~(hit[e] & setup_i);
            stall_sent[e] <= stall_sent[e] & ~(c & ~bus.wdata[`USBEC_B_STALL_SENT])
               | hit[e] & (stall_sent_i | crc_err_i & ~dir[e] & kind[e] == `USBEC_KIND_ISO);
            in_rdy[e] <= in_rdy[e] & ~(c & ~bus.wdata[`USBEC_B_IN_RDY]) | rel_set[e] & dir[e];
            // summary bit falls by itself once the flags are served
            ep_irq_o[e] <= |({overrun[e] | underrun[e], in_nak[e], 1'b0, out_nak[e],
               setup_f[e], out_rcv[e], stall_sent[e], in_rdy[e]} & ien[e]);
         end
      end
   end

   // byte storage: firmware and usb engine each reach their own endpoint
   always_ff @(posedge clk_i) begin
      for (int e = 0; e < NE; e++) begin
         if (rst_i || clear_o[e]) begin
            wp[e] <= '0;
            rp[e] <= '0;
            cnt[e] <= '0;
         end else begin
            logic push, pop;
            push = (wr && bus.addr == `USBEC_OFS_DATA && sel == 3'(e))
                   | (usb_push_i & hit[e]);
            pop = (rd && bus.addr == `USBEC_OFS_DATA && sel == 3'(e))
                  | (usb_pop_i & hit[e]);
            push = push & (cnt[e] != (PW+1)'(DEPTH));
            pop = pop & (cnt[e] != '0);
            if (push) wp[e] <= wp[e] + 1'b1;
            if (pop) rp[e] <= rp[e] + 1'b1;
            cnt[e] <= cnt[e] + (PW+1)'(push) - (PW+1)'(pop);
         end
      end
   end

   // memory write ports for the firmware and the usb engine
   always_ff @(posedge clk_i) begin
      if (wr && bus.addr == `USBEC_OFS_DATA && ep_ok) mem[{sel, wp[sel]}] <= bus.wdata;
      if (usb_push_i && usb_ep_i != `USBEC_EP_NONE) mem[{usb_ep_i, wp[usb_ep_i]}] <= usb_data_i;
   end

   // usb engine byte out; registered so the pop and the data line up
   always_ff @(posedge clk_i) begin
      if (rst_i) usb_data_o <= `USBEC_RST_BYTE;
      else if (usb_pop_i && usb_ep_i != `USBEC_EP_NONE) usb_data_o <= mem[{usb_ep_i, rp[usb_ep_i]}];
   end
endmodule : usbec_device

// ### usbec_host.sv
// controller end: takes wishbone orders and runs them on the endpoint link
// assumes classic wishbone single cycles; one link transfer at a time
`timescale 1ns/1ps
`include "usbec_cfg.svh"
module usbec_host (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // endpoint link
   usbec_if.host bus
);
   usbec_pkg::usbec_hstate_t state;
   usbec_pkg::usbec_byte_t last_rd;
   logic refused;
   logic wb_go, cmd_wr, bad_sel;

   assign wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign cmd_wr = wb_go & wb_we_i & (wb_adr_i == `USBEC_WB_OFS_CMD) & (&wb_sel_i[2:0]);
   // selecting endpoint seven is never passed on
   assign bad_sel = wb_dat_i[`USBEC_B_CMD_WE]
                    && wb_dat_i[`USBEC_F_CMD_ADDR] == `USBEC_OFS_SEL
                    && wb_dat_i[2:0] == `USBEC_EP_NONE;

   // wishbone answer, one cycle after the strobe, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_go;
         if (wb_go && !wb_we_i) begin
            if (wb_adr_i == `USBEC_WB_OFS_STAT) begin
               wb_dat_o <= {22'h000000, refused, state == usbec_pkg::usbec_wait, last_rd};
            end else begin
               wb_dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   // link sequencer: request held until the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= usbec_pkg::usbec_idle;
         bus.req <= 1'b0;
         bus.we <= 1'b0;
         bus.addr <= 4'h0;
         bus.wdata <= 8'h00;
         last_rd <= 8'h00;
         refused <= 1'b0;
      end else begin
         case (state)
            usbec_pkg::usbec_idle: begin
               if (cmd_wr) begin
                  refused <= bad_sel;
                  if (!bad_sel) begin
                     bus.req <= 1'b1;
                     bus.we <= wb_dat_i[`USBEC_B_CMD_WE];
                     bus.addr <= wb_dat_i[`USBEC_F_CMD_ADDR];
                     bus.wdata <= wb_dat_i[`USBEC_F_CMD_DATA];
                     state <= usbec_pkg::usbec_wait;
                  end
               end
            end
            usbec_pkg::usbec_wait: begin
               if (bus.ack) begin
                  bus.req <= 1'b0;
                  if (!bus.we) last_rd <= bus.rdata;
                  state <= usbec_pkg::usbec_idle;
               end
            end
            default: state <= usbec_pkg::usbec_idle;
         endcase
      end
   end
endmodule : usbec_host

// ### usbec_properties.sv
// checker of the endpoint register link: handshake timing and reserved read-back bits
// assumes instantiation beside the link that joins host and device ends
`timescale 1ns/1ps
`include "usbec_cfg.svh"
module usbec_properties (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link signals
   input wire logic req,
   input wire logic we,
   input wire usbec_pkg::usbec_ofs_t addr,
   input wire usbec_pkg::usbec_byte_t wdata,
   input wire logic ack,
   input wire usbec_pkg::usbec_byte_t rdata
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd;
   // a read answer sampled now; offset still held since req drops only after ack
   assign rd = ack && !we;
   ack_one_cycle_a: assert property (req && !ack |=> ack) else $error("link ack late");
   ack_pulse_a: assert property (ack |=> !ack && !req) else $error("ack or req held");
   addr_read_a:
      assert property (rd && addr == `USBEC_OFS_ADDR |-> !rdata[7]) else $error("addr bit7");
   frame_hi_a:
      assert property (rd && addr == `USBEC_OFS_FRM_HI |-> rdata[7:3] == 5'h00) else $error("frm");
   frame_err_a:
      assert property (rd && addr == `USBEC_OFS_FRM_ERR |-> (rdata & 8'hEF) == 8'h00)
         else $error("frame err bits");
   sel_read_a:
      assert property (rd && addr == `USBEC_OFS_SEL |-> rdata[7:3] == 5'h00) else $error("sel");
   self_clear_a:
      assert property (rd && addr == `USBEC_OFS_CTRL |-> (rdata & 8'hDE) == 8'h00)
         else $error("ctrl self clear");
   kind_read_a:
      assert property (rd && addr == `USBEC_OFS_TYPE |-> rdata[5:1] == 5'h00) else $error("type");
   size_read_a:
      assert property (rd && addr == `USBEC_OFS_SIZE |-> !rdata[7] && !rdata[0]) else $error("sz");
   enable_read_a:
      assert property (rd && addr == `USBEC_OFS_IEN |-> !rdata[5]) else $error("enable bit5");
   // main traffic kinds seen on the link
   cover property (ack && we);
   cover property (rd && addr == `USBEC_OFS_CTRL);
   cover property (rd && addr == `USBEC_OFS_FLG);
endmodule : usbec_properties

// ### tb.sv
// bench: wishbone orders run through the host end onto the device end
// assumes both ends share the 40 MHz clock; usb engine events come from here
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic wwe = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, wq, r;
   logic wack, tog = 1'b0, crc = 1'b0;
   logic [11:0] ev = 12'h000;
   logic [2:0] ep = 3'h7;
   logic [10:0] frm = 11'h000;
   logic [7:0] ud = 8'h00;
   logic [6:0] addr_o, stall, act, clr, togo, irq;
   logic [7:0] udo;
   logic fso;
   logic sof_seen = 1'b0;
   int fails = 0;
   int checks_done = 0;
   usbec_if lnk ();
   // free running clock
   always #12.5 clk_i = ~clk_i;
   // frame start is a one-cycle pulse, so remember that it was seen
   always @(posedge clk_i) if (fso) sof_seen <= 1'b1;
   // both ends and the checker on one link
   usbec_host i_usbec_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wq),
      .wb_ack_o(wack), .bus(lnk.host));
   usbec_device i_usbec_device (.clk_i(clk_i), .rst_i(rst_i), .bus(lnk.device), .sof_i(ev[0]),
      .sof_frame_i(frm), .sof_crc_bad_i(crc), .usb_ep_i(ep), .setup_i(ev[1]),
      .setup_dir_i(tog), .out_done_i(ev[2]), .out_toggle_i(tog), .in_done_i(ev[3]),
      .nak_in_i(ev[4]), .nak_out_i(ev[5]), .stall_sent_i(ev[6]), .crc_err_i(ev[7]),
      .overflow_i(ev[8]), .underflow_i(ev[9]), .usb_push_i(ev[10]), .usb_pop_i(ev[11]),
      .usb_data_i(ud), .usb_data_o(udo), .dev_addr_o(addr_o), .frame_start_o(fso), .stall_o(stall),
      .active_o(act), .clear_o(clr), .toggle_o(togo), .ep_irq_o(irq));
   usbec_properties i_usbec_properties (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
      .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic wishbone cycle; a missing ack ends the run
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      wwe <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wack !== 1'b1 && n < 40);
      r = wq;
      cyc <= 1'b0;
      @(posedge clk_i);
      if (n == 40) begin
         fails++;
         tally_and_finish();
      end
   endtask : wb
   // one link access: command, then poll busy so that orders never overlap
   task automatic lk(input logic w, input logic [3:0] o, input logic [7:0] d);
      int n;
      n = 0;
      wb(1'b1, 4'h0, {15'h0000, w, 4'h0, o, d});
      do begin
         wb(1'b0, 4'h4, 32'h0);
         n++;
      end while (r[8] !== 1'b0 && n < 20);
      if (n == 20) begin
         fails++;
         tally_and_finish();
      end
   endtask : lk
   task automatic wr(input logic [3:0] o, input logic [7:0] d);
      lk(1'b1, o, d);
   endtask : wr
   task automatic rc(input logic [3:0] o, input logic [7:0] m, input logic [7:0] e);
      lk(1'b0, o, 8'h00);
      chk(r[7:0] & m, e);
   endtask : rc
   // one-cycle usb engine event on endpoint e
   task automatic fire(input int b, input logic [2:0] e);
      ep <= e;
      ev[b] <= 1'b1;
      @(posedge clk_i);
      ev <= 12'h000;
      ep <= 3'h7;
      repeat (3) @(posedge clk_i);
   endtask : fire
   // main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(4'h0, 8'h2A);
      chk({1'b0, addr_o}, 8'h00);
      rc(4'h0, 8'hFF, 8'h2A);
      wr(4'h0, 8'hAA);
      chk({1'b0, addr_o}, 8'h2A);
      frm <= 11'h5A3;
      crc <= 1'b1;
      chk({7'h00, sof_seen}, 8'h00);
      fire(0, 3'h7);
      chk({7'h00, sof_seen}, 8'h01);
      rc(4'h1, 8'hFF, 8'h05);
      rc(4'h2, 8'hFF, 8'hA3);
      rc(4'h3, 8'hFF, 8'h10);
      wr(4'h4, 8'h01);
      rc(4'h4, 8'hFF, 8'h01);
      wr(4'h5, 8'h02);
      chk({1'b0, clr}, 8'h02);
      wr(4'h5, 8'h00);
      chk({1'b0, clr}, 8'h00);
      wr(4'h7, 8'h81);
      rc(4'h7, 8'hFF, 8'h81);
      wr(4'h8, 8'h66);
      rc(4'h9, 8'h80, 8'h00);
      wr(4'h8, 8'h36);
      rc(4'h9, 8'hFF, 8'h80);
      wr(4'h6, 8'h21);
      chk({1'b0, stall & act}, 8'h02);
      wr(4'h6, 8'h01);
      chk({1'b0, stall}, 8'h02);
      fire(1, 3'h1);
      chk({1'b0, stall}, 8'h00);
      wr(4'h6, 8'h21);
      wr(4'h6, 8'h11);
      chk({1'b0, stall}, 8'h00);
      rc(4'hB, 8'hFF, 8'hA1);
      wr(4'hC, 8'h01);
      chk({1'b0, irq}, 8'h02);
      wr(4'hC, 8'h00);
      chk({1'b0, irq}, 8'h00);
      wr(4'hB, 8'h7A);
      rc(4'hA, 8'hFF, 8'h01);
      rc(4'h9, 8'hFF, 8'h81);
      wr(4'hB, 8'hFF);
      rc(4'h9, 8'h03, 8'h00);
      wr(4'h4, 8'h02);
      wr(4'h7, 8'h80);
      wr(4'h8, 8'h02);
      wr(4'h6, 8'h01);
      tog <= 1'b1;
      fire(2, 3'h2);
      chk({1'b0, togo}, 8'h04);
      rc(4'h9, 8'h0F, 8'h05);
      fire(4, 3'h2);
      fire(5, 3'h2);
      rc(4'hB, 8'hD4, 8'hD4);
      wr(4'h6, 8'h09);
      chk({1'b0, togo}, 8'h00);
      ud <= 8'h5C;
      fire(10, 3'h2);
      rc(4'hD, 8'hFF, 8'h5C);
      ud <= 8'hC3;
      fire(10, 3'h2);
      fire(11, 3'h2);
      chk(udo, 8'hC3);
      wr(4'h4, 8'h03);
      wr(4'h7, 8'h40);
      fire(8, 3'h3);
      rc(4'h9, 8'h40, 8'h40);
      wr(4'h9, 8'h00);
      rc(4'h9, 8'h40, 8'h00);
      wb(1'b1, 4'h0, 32'h0001_0407);
      wb(1'b0, 4'h4, 32'h0);
      chk({7'h00, r[9]}, 8'h01);
      wb(1'b0, 4'h8, 32'h0);
      chk(r[7:0], 8'h00);
      tally_and_finish();
   end
endmodule : tb
